// [verilog/fawc_top.sv]
// flash access wait control: read timing, prefetch, cache, program/erase
`timescale 1ns/1ns
`default_nettype none
`include "fawc_params.svh"
module fawc_top #(
  parameter int ERASE_CYCLES = `FAWC_ERASE_CYC,
  parameter int PROG_CYCLES = `FAWC_PROG_CYC
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [3:0] flash_wait_count_i,
  input wire logic [1:0] flash_wait_extension_i,
  input wire logic safe_access_after_reset_i,
  input wire logic rd_req_i,
  input wire fawc_pkg::fawc_addr_t rd_addr_i,
  input wire logic rd_cached_i,
  output logic rd_ready_o,
  output logic rd_valid_o,
  output fawc_pkg::fawc_word_t rd_data_o,
  input wire logic pe_req_i,
  input wire fawc_pkg::fawc_op_e pe_op_i,
  input wire fawc_pkg::fawc_addr_t pe_addr_i,
  input wire fawc_pkg::fawc_word_t pe_data_i,
  output logic pe_ack_o,
  output logic pe_reject_o,
  output logic [4:0] pe_busy_o,
  output logic [4:0] pe_done_o
);
  import fawc_pkg::*;

  fawc_rd_state_e state;
  fawc_word_t mem [0:`FAWC_ARRAY_WORDS-1];
  fawc_addr_t lat_addr;
  fawc_addr_t pf_addr;
  logic [4:0] cnt;
  logic [4:0] pf_cnt;
  logic pf_valid;
  logic lat_cached;
  logic [2:0] src_mod;
  logic [3:0] c_valid;
  logic [4:0] c_tag [0:3];
  fawc_op_e op_q [0:`FAWC_NUM_MOD-1];
  logic [3:0] word_q [0:`FAWC_NUM_MOD-1];
  fawc_word_t data_q [0:`FAWC_NUM_MOD-1];
  logic [4:0] start;

  // safe bit raises the settings to levels valid for any clock
  wire [3:0] ws_eff = (safe_access_after_reset_i && flash_wait_count_i < `FAWC_WS_SAFE) ?
    `FAWC_WS_SAFE : flash_wait_count_i;
  wire [1:0] ext_eff = (safe_access_after_reset_i && flash_wait_extension_i < `FAWC_EXT_SAFE) ?
    `FAWC_EXT_SAFE : flash_wait_extension_i;
  wire [4:0] base_wait = {1'b0, ws_eff} + {3'h0, ext_eff};
  wire [2:0] rd_mod = rd_addr_i[6:`FAWC_MOD_POS];
  wire [1:0] line = rd_addr_i[1:0];
  wire hit = rd_cached_i && c_valid[line] && (c_tag[line] == rd_addr_i[6:2]);
  wire seq = !rd_cached_i && pf_valid && (rd_addr_i == pf_addr);
  wire [4:0] wait_sel = hit ? 5'h00 :
    rd_cached_i ? base_wait + 5'h01 :
    seq ? pf_cnt : base_wait;
  wire accept = rd_req_i && (state == FAWC_IDLE);
  wire done_rd = (state == FAWC_WAIT) && (cnt == 5'h00);
  wire lat_in_range = lat_addr < 7'(`FAWC_ARRAY_WORDS);
  wire [2:0] pe_mod = pe_addr_i[6:`FAWC_MOD_POS];
  wire [7:0] busy8 = {3'h0, pe_busy_o};
  // a busy module, the module of the last accepted read or of a read accepted in the same cycle must not start; all others may run together
  wire pe_ok = pe_req_i && (pe_mod < 3'(`FAWC_NUM_MOD)) && !busy8[pe_mod] &&
    (pe_mod != src_mod) && !(accept && rd_mod == pe_mod);
  wire pe_done_any = |pe_done_o;

  assign rd_ready_o = (state == FAWC_IDLE);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= FAWC_IDLE;
      cnt <= 5'h00;
      lat_addr <= 7'h00;
      lat_cached <= 1'b0;
    end else begin
      case (state)
        FAWC_IDLE: begin
          if (accept) begin
            state <= FAWC_WAIT;
            cnt <= wait_sel;
            lat_addr <= rd_addr_i;
            lat_cached <= rd_cached_i;
          end
        end
        FAWC_WAIT: begin
          if (cnt == 5'h00) begin
            state <= FAWC_IDLE;
          end else begin
            cnt <= cnt - 5'h01;
          end
        end
        default: state <= FAWC_IDLE;
      endcase
    end
  end

  // array is held in flops, so the cache keeps tags only
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o <= `FAWC_ERASED_WORD;
      src_mod <= `FAWC_NO_MOD;
    end else begin
      rd_valid_o <= done_rd;
      if (done_rd) begin
        rd_data_o <= lat_in_range ? mem[lat_addr] : `FAWC_ERASED_WORD;
      end
      if (accept) begin
        src_mod <= rd_mod;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      c_valid <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        c_tag[i] <= 5'h00;
      end
    end else if (pe_done_any) begin
      c_valid <= 4'h0; // stale lines would hide new array content
    end else if (done_rd && lat_cached) begin
      c_valid[lat_addr[1:0]] <= 1'b1;
      c_tag[lat_addr[1:0]] <= lat_addr[6:2];
    end
  end

  // prefetch of the next word runs out its wait behind the current uncached read
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pf_valid <= 1'b0;
      pf_addr <= 7'h00;
      pf_cnt <= 5'h00;
    end else if (done_rd && !lat_cached) begin
      pf_valid <= 1'b1;
      pf_addr <= lat_addr + 7'h01;
      pf_cnt <= base_wait;
    end else if (pf_cnt != 5'h00) begin
      pf_cnt <= pf_cnt - 5'h01;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pe_ack_o <= 1'b0;
      pe_reject_o <= 1'b0;
    end else begin
      pe_ack_o <= pe_ok;
      pe_reject_o <= pe_req_i && !pe_ok;
    end
  end

  for (genvar m = 0; m < `FAWC_NUM_MOD; m++) begin : g_mod
    assign start[m] = pe_ok && (pe_mod == 3'(m));
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        op_q[m] <= FAWC_OP_ERASE;
        word_q[m] <= 4'h0;
        data_q[m] <= `FAWC_ERASED_WORD;
      end else if (start[m]) begin
        op_q[m] <= pe_op_i;
        word_q[m] <= pe_addr_i[3:0];
        data_q[m] <= pe_data_i;
      end
    end
    fawc_timer fawc_timer_i (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .start_i(start[m]),
      .len_i((pe_op_i == FAWC_OP_PROG) ? 20'(PROG_CYCLES) : 20'(ERASE_CYCLES)),
      .busy_o(pe_busy_o[m]),
      .done_o(pe_done_o[m])
    );
  end

  // array content changes only when an operation ends
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < `FAWC_ARRAY_WORDS; i++) begin
        mem[i] <= `FAWC_ERASED_WORD;
      end
    end else begin
      for (int m = 0; m < `FAWC_NUM_MOD; m++) begin
        for (int w = 0; w < `FAWC_MOD_WORDS; w++) begin
          if (pe_done_o[m] && op_q[m] == FAWC_OP_ERASE &&
              w[3:`FAWC_PAGE_POS] == word_q[m][3:`FAWC_PAGE_POS]) begin
            mem[m * `FAWC_MOD_WORDS + w] <= `FAWC_ERASED_WORD;
          end else if (pe_done_o[m] && op_q[m] == FAWC_OP_PROG && w[3:0] == word_q[m]) begin
            mem[m * `FAWC_MOD_WORDS + w] <= data_q[m];
          end
        end
      end
    end
  end

  // helper: latency and kind of the read in flight
  logic [5:0] lat;
  logic k_hit, k_miss, k_seq, any_pe;
  logic [4:0] k_base;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lat <= 6'h00;
      k_hit <= 1'b0;
      k_miss <= 1'b0;
      k_seq <= 1'b0;
      k_base <= 5'h00;
      any_pe <= 1'b0;
    end else begin
      lat <= accept ? 6'h01 : lat + 6'h01;
      if (accept) begin
        k_hit <= hit;
        k_miss <= rd_cached_i && !hit;
        k_seq <= seq;
        k_base <= base_wait;
      end
      if (pe_ack_o) begin
        any_pe <= 1'b1;
      end
    end
  end

  property p_random_wait;
    @(posedge clk_i) disable iff (!resetn_i)
      (rd_valid_o && !k_hit && !k_miss && !k_seq) |-> (lat == {1'b0, k_base} + 6'h02);
  endproperty
  a_random_wait: assert property (p_random_wait) else $error("random read latency");

  property p_hit_fast;
    @(posedge clk_i) disable iff (!resetn_i)
      (accept && hit) |-> ##2 rd_valid_o;
  endproperty
  a_hit_fast: assert property (p_hit_fast) else $error("cache hit not zero wait");

  property p_miss_extra;
    @(posedge clk_i) disable iff (!resetn_i)
      (rd_valid_o && k_miss) |-> (lat == {1'b0, k_base} + 6'h03);
  endproperty
  a_miss_extra: assert property (p_miss_extra) else $error("cache miss latency");

  property p_seq_bound;
    @(posedge clk_i) disable iff (!resetn_i)
      (rd_valid_o && k_seq) |-> (lat <= {1'b0, k_base} + 6'h02);
  endproperty
  a_seq_bound: assert property (p_seq_bound) else $error("sequential read too slow");

  property p_prefetch_ready;
    @(posedge clk_i) disable iff (!resetn_i)
      (accept && seq && pf_cnt == 5'h00) |=> !rd_valid_o ##1 rd_valid_o;
  endproperty
  a_prefetch_ready: assert property (p_prefetch_ready) else $error("prefetch not used");

  property p_no_pe_on_read;
    @(posedge clk_i) disable iff (!resetn_i)
      pe_req_i && (pe_mod == src_mod) |=> pe_reject_o && !pe_ack_o;
  endproperty
  a_no_pe_on_read: assert property (p_no_pe_on_read) else $error("read module accepted");

  property p_free_mod;
    @(posedge clk_i) disable iff (!resetn_i)
      (pe_req_i && pe_mod == `FAWC_FREE_MOD && !pe_busy_o[4] && src_mod != `FAWC_FREE_MOD &&
       !(accept && rd_mod == `FAWC_FREE_MOD)) |=> pe_ack_o ##1 pe_busy_o[4];
  endproperty
  a_free_mod: assert property (p_free_mod) else $error("module four refused");

  property p_parallel;
    @(posedge clk_i) disable iff (!resetn_i)
      (pe_req_i && pe_mod < 3'(`FAWC_NUM_MOD) && !busy8[pe_mod] && pe_mod != src_mod &&
       !(accept && rd_mod == pe_mod)) |=> pe_ack_o;
  endproperty
  a_parallel: assert property (p_parallel) else $error("idle module refused");

  property p_erased;
    @(posedge clk_i) disable iff (!resetn_i)
      (rd_valid_o && !any_pe) |-> (rd_data_o == `FAWC_ERASED_WORD);
  endproperty
  a_erased: assert property (p_erased) else $error("array not erased at start");

  c_hit: cover property (@(posedge clk_i) disable iff (!resetn_i) accept && hit);
  c_seq: cover property (@(posedge clk_i) disable iff (!resetn_i) accept && seq);
  c_two_pe: cover property (@(posedge clk_i) disable iff (!resetn_i) pe_busy_o[0] && pe_busy_o[4]);
  c_reject: cover property (@(posedge clk_i) disable iff (!resetn_i) pe_reject_o);
endmodule
`default_nettype wire

// [verilog/fawc_params.svh]
// constants of the flash access and wait control block
`ifndef FAWC_PARAMS_SVH
`define FAWC_PARAMS_SVH
`define FAWC_CLK_MHZ 125
`define FAWC_T_ERASE_US 7000
`define FAWC_T_PROG_US 3000
`define FAWC_ERASE_CYC (`FAWC_T_ERASE_US * `FAWC_CLK_MHZ)
`define FAWC_PROG_CYC (`FAWC_T_PROG_US * `FAWC_CLK_MHZ)
`define FAWC_NUM_MOD 5
`define FAWC_MOD_WORDS 16
`define FAWC_ARRAY_WORDS (`FAWC_NUM_MOD * `FAWC_MOD_WORDS)
`define FAWC_MOD_POS 4
`define FAWC_PAGE_POS 2
`define FAWC_ERASED_WORD 16'hFFFF
`define FAWC_WS_SAFE 4'h4
`define FAWC_EXT_SAFE 2'h1
`define FAWC_NO_MOD 3'h7
`define FAWC_FREE_MOD 3'h4
`endif

// [verilog/fawc_pkg.sv]
// types shared by the flash access and wait control block
package fawc_pkg;
  typedef enum {FAWC_IDLE, FAWC_WAIT} fawc_rd_state_e;
  typedef enum logic {FAWC_OP_ERASE, FAWC_OP_PROG} fawc_op_e;
  typedef logic [15:0] fawc_word_t;
  typedef logic [6:0] fawc_addr_t;
  typedef logic [19:0] fawc_len_t;
endpackage

// [verilog/fawc_timer.sv]
// program/erase duration timer of one flash module
`timescale 1ns/1ns
`default_nettype none
module fawc_timer (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire fawc_pkg::fawc_len_t len_i,
  output logic busy_o,
  output logic done_o
);
  import fawc_pkg::*;
  fawc_len_t cnt;
  fawc_len_t age;
  fawc_len_t len_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      cnt <= 20'h00000;
    end else begin
      done_o <= busy_o && (cnt == 20'h00000);
      if (start_i && !busy_o) begin
        busy_o <= 1'b1;
        cnt <= len_i - 20'h00001;
      end else if (busy_o) begin
        if (cnt == 20'h00000) begin
          busy_o <= 1'b0;
        end else begin
          cnt <= cnt - 20'h00001;
        end
      end
    end
  end

  // helper: busy cycles seen since start
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      age <= 20'h00000;
      len_q <= 20'h00000;
    end else if (start_i && !busy_o) begin
      age <= 20'h00000;
      len_q <= len_i;
    end else if (busy_o) begin
      age <= age + 20'h00001;
    end
  end

  property p_duration;
    @(posedge clk_i) disable iff (!resetn_i)
      $rose(done_o) |-> (age == len_q);
  endproperty
  a_duration: assert property (p_duration) else $error("operation length wrong");

  property p_busy_held;
    @(posedge clk_i) disable iff (!resetn_i)
      (busy_o && cnt != 20'h00000) |=> busy_o && !done_o;
  endproperty
  a_busy_held: assert property (p_busy_held) else $error("busy dropped early");
endmodule
`default_nettype wire

// [verif/fawc_core_model.sv]
// core-side requester that fetches words over the flash read handshake
`timescale 1ns/1ns
`default_nettype none
module fawc_core_model (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic go_i,
  input wire fawc_pkg::fawc_addr_t addr_i,
  input wire logic cached_i,
  output logic rd_req_o,
  output fawc_pkg::fawc_addr_t rd_addr_o,
  output logic rd_cached_o,
  input wire logic rd_ready_i,
  input wire logic rd_valid_i,
  input wire fawc_pkg::fawc_word_t rd_data_i,
  output logic done_o,
  output int lat_o,
  output fawc_pkg::fawc_word_t data_o
);
  import fawc_pkg::*;
  logic wait_ans;
  int cnt;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_req_o <= 1'b0;
      rd_addr_o <= 7'h00;
      rd_cached_o <= 1'b0;
      wait_ans <= 1'b0;
      cnt <= 0;
      done_o <= 1'b0;
      lat_o <= 0;
      data_o <= 16'h0000;
    end else begin
      done_o <= 1'b0;
      if (rd_req_o && rd_ready_i) begin
        // released lines show the inverse so a stale value never passes
        rd_req_o <= 1'b0;
        rd_addr_o <= ~rd_addr_o;
        rd_cached_o <= ~rd_cached_o;
        wait_ans <= 1'b1;
        cnt <= 1;
      end else if (go_i && !rd_req_o && !wait_ans) begin
        rd_req_o <= 1'b1;
        rd_addr_o <= addr_i;
        rd_cached_o <= cached_i;
      end
      if (wait_ans && rd_valid_i) begin
        wait_ans <= 1'b0;
        done_o <= 1'b1;
        lat_o <= cnt;
        data_o <= rd_data_i;
      end else if (wait_ans) begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

// [verif/flash_access_wait_control_bench.sv]
// self-checking bench of the flash access and wait control block
`timescale 1ns/1ns
`default_nettype none
module flash_access_wait_control_bench;
  import fawc_pkg::*;
  localparam int PROG = 16;
  localparam int ERASE = 32;
  logic clk, resetn, safe, go, rc, pq, rq, rcd, ry, rv, pk, pj, dn;
  logic [3:0] ws;
  logic [1:0] ext;
  logic [4:0] pbusy, pdone;
  fawc_addr_t ra, rqa, pa;
  fawc_word_t pd, rdat, dat;
  fawc_op_e po;
  int lat, bad_count, check_count;
  fawc_top #(.ERASE_CYCLES(ERASE), .PROG_CYCLES(PROG)) fawc_top_i (.clk_i(clk),
    .resetn_i(resetn), .flash_wait_count_i(ws), .flash_wait_extension_i(ext),
    .safe_access_after_reset_i(safe), .rd_req_i(rq), .rd_addr_i(rqa), .rd_cached_i(rcd),
    .rd_ready_o(ry), .rd_valid_o(rv), .rd_data_o(rdat), .pe_req_i(pq), .pe_op_i(po),
    .pe_addr_i(pa), .pe_data_i(pd), .pe_ack_o(pk), .pe_reject_o(pj), .pe_busy_o(pbusy),
    .pe_done_o(pdone));
  fawc_core_model fawc_core_model_i (.clk_i(clk), .resetn_i(resetn), .go_i(go),
    .addr_i(ra), .cached_i(rc), .rd_req_o(rq), .rd_addr_o(rqa), .rd_cached_o(rcd),
    .rd_ready_i(ry), .rd_valid_i(rv), .rd_data_i(rdat), .done_o(dn), .lat_o(lat),
    .data_o(dat));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk_w(input string nm, input fawc_word_t e, input fawc_word_t g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_n(input string nm, input int e, input int g);
    check_count++;
    if (g != e) begin
      bad_count++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic chk_b(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask
  // read one word, check data and edges from take to answer
  task automatic rd(input fawc_addr_t a, input logic c, input fawc_word_t ed, input int el);
    int n;
    @(posedge clk);
    go <= 1'b1;
    ra <= a;
    rc <= c;
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    while (dn !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk_b("rd_answer", 1'b1, dn);
    chk_w("rd_data", ed, dat);
    chk_n("rd_latency", el, lat);
  endtask
  task automatic pe(input fawc_op_e op, input fawc_addr_t a, input fawc_word_t d,
    input logic ok);
    @(posedge clk);
    pq <= 1'b1;
    po <= op;
    pa <= a;
    pd <= d;
    @(posedge clk);
    pq <= 1'b0;
    pd <= ~d;
    @(negedge clk);
    chk_b("pe_ack", ok, pk);
    chk_b("pe_reject", !ok, pj);
  endtask
  task automatic wait_done(input int m, input int len);
    int n;
    n = 1;
    @(negedge clk);
    while (pbusy[m] === 1'b1 && n < 100) begin
      n++;
      @(negedge clk);
    end
    chk_n("busy_len", len, n);
    chk_b("pe_done", 1'b1, pdone[m]);
  endtask
  task automatic t_reset();
    chk_b("rd_ready", 1'b1, ry);
    chk_w("rd_data_rst", 16'hFFFF, rdat);
    chk_b("pe_busy", 1'b1, pbusy === 5'h00);
    rd(7'h00, 1'b0, 16'hFFFF, 7);
    rd(7'h4F, 1'b0, 16'hFFFF, 7);
    $display("test reset done");
  endtask
  task automatic t_waits();
    for (int w = 4; w < 8; w++) begin
      for (int e = 1; e < 3; e++) begin
        @(posedge clk);
        ws <= w[3:0];
        ext <= e[1:0];
        rd(7'(2 * w + 2), 1'b0, 16'hFFFF, w + e + 2);
      end
    end
    @(posedge clk);
    ws <= 4'h0;
    ext <= 2'h0;
    safe <= 1'b1;
    rd(7'h07, 1'b0, 16'hFFFF, 7);
    @(posedge clk);
    safe <= 1'b0;
    ws <= 4'h4;
    ext <= 2'h1;
    $display("test waits done");
  endtask
  task automatic t_prefetch_cache();
    rd(7'h20, 1'b0, 16'hFFFF, 7);
    repeat (10) @(posedge clk);
    rd(7'h21, 1'b0, 16'hFFFF, 2);
    // follows at once: two of five prefetch waits are still to run
    rd(7'h22, 1'b0, 16'hFFFF, 4);
    rd(7'h30, 1'b1, 16'hFFFF, 8);
    rd(7'h30, 1'b1, 16'hFFFF, 2);
    $display("test prefetch cache done");
  endtask
  task automatic t_prog_erase();
    int n;
    pe(FAWC_OP_PROG, 7'h13, 16'hA5C3, 1'b1);
    wait_done(1, PROG);
    rd(7'h13, 1'b0, 16'hA5C3, 7);
    pe(FAWC_OP_PROG, 7'h12, 16'h0F0F, 1'b0);
    rd(7'h00, 1'b0, 16'hFFFF, 7);
    pe(FAWC_OP_ERASE, 7'h10, 16'h0000, 1'b1);
    wait_done(1, ERASE);
    rd(7'h13, 1'b0, 16'hFFFF, 7);
    pe(FAWC_OP_PROG, 7'h40, 16'h1234, 1'b1);
    pe(FAWC_OP_PROG, 7'h25, 16'h5AA5, 1'b1);
    pe(FAWC_OP_PROG, 7'h41, 16'h0000, 1'b0);
    pe(FAWC_OP_ERASE, 7'h50, 16'h0000, 1'b0);
    chk_b("par_busy", 1'b1, pbusy[4] & pbusy[2]);
    n = 0;
    while (pbusy !== 5'h00 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk_b("all_idle", 1'b1, pbusy === 5'h00);
    rd(7'h40, 1'b0, 16'h1234, 7);
    rd(7'h25, 1'b0, 16'h5AA5, 7);
    $display("test program erase done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    // no tests should get near this span, so reaching it means a hang
    #200000;
    bad_count++;
    close_out();
  end
  initial begin
    resetn = 1'b0;
    ws = 4'h4;
    ext = 2'h1;
    safe = 1'b0;
    go = 1'b0;
    ra = 7'h00;
    rc = 1'b0;
    pq = 1'b0;
    po = FAWC_OP_ERASE;
    pa = 7'h00;
    pd = 16'h0000;
    bad_count = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    t_reset();
    t_waits();
    t_prefetch_cache();
    t_prog_erase();
    close_out();
  end
endmodule
`default_nettype wire
